//--- rbt_pkg.sv
package rbt_pkg;
    // -----------------------------------------------------------------
    // Geometry
    // -----------------------------------------------------------------
    localparam int SLICE_W = 8;
    localparam int SLICES = 2;
    localparam int BUS_W = SLICE_W * SLICES;
    localparam int FIFO_DEPTH = 16;
    // Snapshot word: capture flags, B registers, A registers.
    localparam int FLAG_W = 2 * SLICES;
    localparam int SNAP_W = 2 * BUS_W + FLAG_W;
    localparam int SNAP_A_LSB = 0;
    localparam int SNAP_B_LSB = BUS_W;
    localparam int SNAP_F_LSB = 2 * BUS_W;
    // -----------------------------------------------------------------
    // Reset values
    // -----------------------------------------------------------------
    localparam logic CAPT_PREV_RST = 1'h1;
    localparam logic OE_RST = 1'h0;
    localparam logic FLAG_RST = 1'h0;
endpackage

//--- rbt_fifo_if.sv
`timescale 1ns/1ns
interface rbt_fifo_if #(
    parameter int W = rbt_pkg::SNAP_W
);
    logic push_valid;
    logic push_ready;
    logic [W-1:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [W-1:0] pop_data;

    modport user (
        output push_valid,
        input push_ready,
        output push_data,
        input pop_valid,
        output pop_ready,
        input pop_data
    );

    modport store (
        input push_valid,
        output push_ready,
        input push_data,
        output pop_valid,
        input pop_ready,
        output pop_data
    );
endinterface

//--- rbt_fifo.sv
`timescale 1ns/1ns
module rbt_fifo #(
    parameter int W = rbt_pkg::SNAP_W,
    parameter int DEPTH = rbt_pkg::FIFO_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_reset,
    rbt_fifo_if.store fifo
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic do_push;
    logic do_pop;

    // -----------------------------------------------------------------
    // Handshake
    // -----------------------------------------------------------------
    assign fifo.push_ready = (count_q != (AW+1)'(DEPTH));
    assign fifo.pop_valid = (count_q != '0);
    assign fifo.pop_data = mem_q[rd_ptr_q];
    assign do_push = fifo.push_valid && fifo.push_ready;
    assign do_pop = fifo.pop_valid && fifo.pop_ready;

    // -----------------------------------------------------------------
    // Storage
    // -----------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (do_push) begin
            mem_q[wr_ptr_q] <= fifo.push_data;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
            end
            if (do_push && !do_pop) begin
                count_q <= count_q + 1'b1;
            end else if (do_pop && !do_push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule

//--- rbt_transceiver.sv
`timescale 1ns/1ns
// Functional notes
// (R1) Two identical independent 8-bit slices form the 16-bit transceiver.
// (R2) Capture clock rising edges load A and B registers, ignoring controls.
// (R3) Register inputs always sample the bus, even while this device drives it.
// (R4) Enable low and enable_n high: drive neither bus, still store both.
// (R5) Both enables low, A select low: drive bus A with live bus B.
// (R6) Both enables low, A select high: drive bus A from B register.
// (R7) Both enables high, B select low: drive bus B with live bus A.
// (R8) Both enables high, B select high: drive bus B from A register.
// (R9) Enable high, enable_n low, both selects high: both stored paths drive.
// (R10) Bus B carrying A data lets a capture store A in both registers.
// (R11) Bus A carrying B data lets a capture store B in both registers.
// (R12) Live path: both capture clocks may rise together.
// (R13) Stored path: the controller must stagger the two capture clocks.
// (R14) Live both ways: each bus drives the other, holding its last value; the registered paths swap unequal bus values each clock.
// (R15) Storage registers have no reset; undefined until first capture.
module rbt_transceiver #(
    parameter int SLICE_W = rbt_pkg::SLICE_W,
    parameter int SLICES = rbt_pkg::SLICES,
    parameter int FIFO_DEPTH = rbt_pkg::FIFO_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [SLICE_W*SLICES-1:0] i_bus_a,
    output logic [SLICE_W*SLICES-1:0] o_bus_a,
    output logic [SLICE_W*SLICES-1:0] o_bus_a_oe,
    input wire logic [SLICE_W*SLICES-1:0] i_bus_b,
    output logic [SLICE_W*SLICES-1:0] o_bus_b,
    output logic [SLICE_W*SLICES-1:0] o_bus_b_oe,
    input wire logic [SLICES-1:0] i_b_side_drive_enable,
    input wire logic [SLICES-1:0] i_a_side_drive_enable_n,
    input wire logic [SLICES-1:0] i_a_capture_clock,
    input wire logic [SLICES-1:0] i_b_capture_clock,
    input wire logic [SLICES-1:0] i_b_output_source_select,
    input wire logic [SLICES-1:0] i_a_output_source_select,
    output logic o_snap_space,
    output logic o_snap_overflow,
    output logic o_snap_valid,
    input wire logic i_snap_ready,
    output logic [2*SLICE_W*SLICES+2*SLICES-1:0] o_snap_data
);
    localparam int BUS_W = SLICE_W * SLICES;
    localparam int SNAP_W = 2 * BUS_W + 2 * SLICES;

    logic [BUS_W-1:0] a_reg_q;
    logic [BUS_W-1:0] a_reg_d;
    logic [BUS_W-1:0] b_reg_q;
    logic [BUS_W-1:0] b_reg_d;
    logic [SLICES-1:0] a_prev_q;
    logic [SLICES-1:0] b_prev_q;
    logic [SLICES-1:0] a_edge;
    logic [SLICES-1:0] b_edge;
    logic any_edge;
    logic [BUS_W-1:0] a_oe_d;
    logic [BUS_W-1:0] b_oe_d;
    logic [BUS_W-1:0] a_out_d;
    logic [BUS_W-1:0] b_out_d;

    rbt_fifo_if #(.W(SNAP_W)) snap_if ();

    // -----------------------------------------------------------------
    // Capture clock edge detection
    // -----------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            a_prev_q <= {SLICES{rbt_pkg::CAPT_PREV_RST}};
            b_prev_q <= {SLICES{rbt_pkg::CAPT_PREV_RST}};
        end else begin
            a_prev_q <= i_a_capture_clock;
            b_prev_q <= i_b_capture_clock;
        end
    end

    assign a_edge = i_a_capture_clock & ~a_prev_q;
    assign b_edge = i_b_capture_clock & ~b_prev_q;
    assign any_edge = |{a_edge, b_edge};

    // -----------------------------------------------------------------
    // Per-slice storage and drive
    // -----------------------------------------------------------------
    for (genvar s = 0; s < SLICES; s++) begin : g_slice // (R1)
        localparam int LO = s * SLICE_W;

        // Loads depend only on the capture edge and the bus pins.
        assign a_reg_d[LO +: SLICE_W] = a_edge[s]
            ? i_bus_a[LO +: SLICE_W] // (R2) (R3)
            : a_reg_q[LO +: SLICE_W];
        assign b_reg_d[LO +: SLICE_W] = b_edge[s]
            ? i_bus_b[LO +: SLICE_W] // (R2) (R3)
            : b_reg_q[LO +: SLICE_W];

        assign a_oe_d[LO +: SLICE_W] =
            {SLICE_W{!i_a_side_drive_enable_n[s]}}; // (R4) (R9)
        assign b_oe_d[LO +: SLICE_W] =
            {SLICE_W{i_b_side_drive_enable[s]}}; // (R4) (R9)

        // Live paths feed back into the capture inputs, so a capture
        // stores the driven value in both registers.
        assign a_out_d[LO +: SLICE_W] = i_a_output_source_select[s]
            ? b_reg_q[LO +: SLICE_W] // (R6) (R9)
            : i_bus_b[LO +: SLICE_W]; // (R5) (R11) (R14)
        assign b_out_d[LO +: SLICE_W] = i_b_output_source_select[s]
            ? a_reg_q[LO +: SLICE_W] // (R8) (R9)
            : i_bus_a[LO +: SLICE_W]; // (R7) (R10) (R14)
    end

    // Storage has no reset on purpose.
    always_ff @(posedge i_clk) begin
        a_reg_q <= a_reg_d; // (R15)
        b_reg_q <= b_reg_d; // (R15)
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_bus_a_oe <= {BUS_W{rbt_pkg::OE_RST}};
            o_bus_b_oe <= {BUS_W{rbt_pkg::OE_RST}};
        end else begin
            o_bus_a_oe <= a_oe_d; // (R4)
            o_bus_b_oe <= b_oe_d; // (R4)
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_bus_a <= '0;
            o_bus_b <= '0;
        end else begin
            o_bus_a <= a_out_d; // (R5) (R6)
            o_bus_b <= b_out_d; // (R7) (R8)
        end
    end

    // -----------------------------------------------------------------
    // Snapshot log
    // -----------------------------------------------------------------
    // Simultaneous edges are taken together in one word.
    assign snap_if.push_valid = any_edge; // (R12)
    assign snap_if.push_data = {b_edge, a_edge, b_reg_d, a_reg_d};

    rbt_fifo #(
        .W(SNAP_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .fifo(snap_if.store)
    );

    assign snap_if.pop_ready = !o_snap_valid || i_snap_ready;

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_snap_valid <= rbt_pkg::FLAG_RST;
            o_snap_data <= '0;
        end else if (snap_if.pop_ready) begin
            o_snap_valid <= snap_if.pop_valid;
            o_snap_data <= snap_if.pop_data;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_snap_space <= rbt_pkg::FLAG_RST;
        end else begin
            o_snap_space <= snap_if.push_ready;
        end
    end

    // Sticky until reset: a capture found the log full.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_snap_overflow <= rbt_pkg::FLAG_RST;
        end else if (any_edge && !snap_if.push_ready) begin
            o_snap_overflow <= 1'b1;
        end
    end
endmodule

//--- rbt_sva.sv
`timescale 1ns/1ns
// ----
// Port checks.
// ----
module rbt_sva #(
    parameter int SLICE_W = 8,
    parameter int SLICES = 2
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [SLICE_W*SLICES-1:0] i_bus_a,
    input wire logic [SLICE_W*SLICES-1:0] i_bus_b,
    input wire logic [SLICE_W*SLICES-1:0] o_bus_a,
    input wire logic [SLICE_W*SLICES-1:0] o_bus_b,
    input wire logic [SLICE_W*SLICES-1:0] o_bus_a_oe,
    input wire logic [SLICE_W*SLICES-1:0] o_bus_b_oe,
    input wire logic [SLICES-1:0] i_b_side_drive_enable,
    input wire logic [SLICES-1:0] i_a_side_drive_enable_n,
    input wire logic [SLICES-1:0] i_a_capture_clock,
    input wire logic [SLICES-1:0] i_b_capture_clock,
    input wire logic [SLICES-1:0] i_b_output_source_select,
    input wire logic [SLICES-1:0] i_a_output_source_select,
    input wire logic o_snap_valid
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    logic [SLICES-1:0] pa_q, pb_q;
    logic [SLICE_W*SLICES-1:0] ra_q, rb_q;
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            pa_q <= '1;
            pb_q <= '1;
        end else begin
            pa_q <= i_a_capture_clock;
            pb_q <= i_b_capture_clock;
        end
    end
    always_ff @(posedge i_clk) begin
        for (int s = 0; s < SLICES; s++) begin
            if (i_a_capture_clock[s] && !pa_q[s] && !i_reset) begin
                ra_q[s*SLICE_W+:SLICE_W] <= i_bus_a[s*SLICE_W+:SLICE_W];
            end
            if (i_b_capture_clock[s] && !pb_q[s] && !i_reset) begin
                rb_q[s*SLICE_W+:SLICE_W] <= i_bus_b[s*SLICE_W+:SLICE_W];
            end
        end
    end
    for (genvar s = 0; s < SLICES; s++) begin : g_s
        localparam int L = s * SLICE_W;
        wire logic ea = !i_a_side_drive_enable_n[s];
        wire logic eb = i_b_side_drive_enable[s];
        wire logic sa = i_a_output_source_select[s];
        wire logic sb = i_b_output_source_select[s];
        chk_isolate_off:
            assert property (!ea && !eb |=> o_bus_a_oe[L+:SLICE_W] == 0
            && o_bus_b_oe[L+:SLICE_W] == 0) else $error("bus driven");
        chk_a_drive_on:
            assert property (ea |=> &o_bus_a_oe[L+:SLICE_W])
            else $error("bus a not driven");
        chk_b_drive_on:
            assert property (eb |=> &o_bus_b_oe[L+:SLICE_W])
            else $error("bus b not driven");
        chk_a_live_data:
            assert property (ea && !sa |=> o_bus_a[L+:SLICE_W] ==
            $past(i_bus_b[L+:SLICE_W])) else $error("bus a live data");
        chk_a_stored_data:
            assert property (ea && sa |=> o_bus_a[L+:SLICE_W] ==
            $past(rb_q[L+:SLICE_W])) else $error("bus a stored data");
        chk_b_live_data:
            assert property (eb && !sb |=> o_bus_b[L+:SLICE_W] ==
            $past(i_bus_a[L+:SLICE_W])) else $error("bus b live data");
        chk_b_stored_data:
            assert property (eb && sb |=> o_bus_b[L+:SLICE_W] ==
            $past(ra_q[L+:SLICE_W])) else $error("bus b stored data");
        chk_both_stored:
            assert property (ea && eb && sa && sb |=>
            &o_bus_a_oe[L+:SLICE_W] && &o_bus_b_oe[L+:SLICE_W])
            else $error("both buses not driven");
        chk_capture_logged:
            assert property (i_a_capture_clock[s] && !pa_q[s] &&
            !o_snap_valid |-> ##[1:2] o_snap_valid)
            else $error("capture not logged");
        cover property (ea && eb && !sa && !sb);
        cover property (ea && eb && sa && sb);
        cover property (!ea && !eb && i_b_capture_clock[s] && !pb_q[s]);
    end
endmodule
bind rbt_transceiver rbt_sva #(.SLICE_W(SLICE_W), .SLICES(SLICES)) u_sva (
    .i_clk(i_clk), .i_reset(i_reset), .i_bus_a(i_bus_a), .i_bus_b(i_bus_b),
    .o_bus_a(o_bus_a), .o_bus_b(o_bus_b), .o_bus_a_oe(o_bus_a_oe),
    .o_bus_b_oe(o_bus_b_oe), .i_b_side_drive_enable(i_b_side_drive_enable),
    .i_a_side_drive_enable_n(i_a_side_drive_enable_n),
    .i_a_capture_clock(i_a_capture_clock),
    .i_b_capture_clock(i_b_capture_clock),
    .i_b_output_source_select(i_b_output_source_select),
    .i_a_output_source_select(i_a_output_source_select),
    .o_snap_valid(o_snap_valid));

//--- rbt_bus_agent.sv
`timescale 1ns/1ns
// ----
// Outside agent; a released undriven bit floats to its inverse.
// ----
module rbt_bus_agent (
    input wire logic i_clk,
    input wire logic [15:0] i_dev,
    input wire logic [15:0] i_dev_oe,
    input wire logic i_drive,
    input wire logic [15:0] i_val,
    output logic [15:0] o_level
);
    logic [15:0] last_q;
    always_ff @(posedge i_clk) begin
        last_q <= o_level;
    end
    always_comb begin
        o_level = i_dev_oe & i_dev | ~i_dev_oe & (i_drive ? i_val : ~last_q);
    end
endmodule

//--- tb_top.sv
`timescale 1ns/1ns
// ----
// Testbench.
// ----
module tb_top;
    logic i_clk = 1'h0;
    logic i_reset = 1'h1;
    logic [15:0] va = 16'h0, vb = 16'h0, la, lb, ra, rb;
    logic [15:0] w_a, w_b, o_a, o_b, oe_a, oe_b;
    logic [1:0] en_b = '0, en_n = '1, sl_b = '0, sl_a = '0;
    logic [1:0] ck_a = '0, ck_b = '0;
    logic dr_a = 1'h1, dr_b = 1'h1, rdy = 1'h0, stall = 1'h0;
    logic sv, sp, so;
    logic [35:0] sd;
    logic [35:0] exp_q[$];
    logic [3:0] c;
    logic [5:0] tbl[9] = '{6'h13, 6'h33, 6'h38, 6'h03, 6'h04, 6'h2D,
        6'h2E, 6'h30, 6'h20};
    int failures = 0, cmp_count = 0;
    rbt_transceiver uut (.i_clk(i_clk), .i_reset(i_reset), .i_bus_a(w_a),
        .o_bus_a(o_a), .o_bus_a_oe(oe_a), .i_bus_b(w_b), .o_bus_b(o_b),
        .o_bus_b_oe(oe_b), .i_b_side_drive_enable(en_b),
        .i_a_side_drive_enable_n(en_n), .i_a_capture_clock(ck_a),
        .i_b_capture_clock(ck_b), .i_b_output_source_select(sl_b),
        .i_a_output_source_select(sl_a), .o_snap_space(sp),
        .o_snap_overflow(so), .o_snap_valid(sv), .i_snap_ready(rdy),
        .o_snap_data(sd));
    rbt_bus_agent u_pa (.i_clk(i_clk), .i_dev(o_a), .i_dev_oe(oe_a),
        .i_drive(dr_a), .i_val(va), .o_level(w_a));
    rbt_bus_agent u_pb (.i_clk(i_clk), .i_dev(o_b), .i_dev_oe(oe_b),
        .i_drive(dr_b), .i_val(vb), .o_level(w_b));
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic step(input logic [3:0] m, input logic [1:0] cp);
        en_b <= {2{m[3]}};
        en_n <= {2{m[2]}};
        sl_b <= {2{m[1]}};
        sl_a <= {2{m[0]}};
        @(posedge i_clk);
        dr_a <= m[2];
        dr_b <= !m[3];
        va <= 16'($urandom);
        vb <= 16'($urandom);
        repeat (3) @(posedge i_clk);
        #1;
        if (m == 4'h8) begin
            lb = la;
        end else if (m[3] && !m[1]) begin
            la = m[2] ? va : rb;
            lb = la;
        end else begin
            lb = m[3] ? ra : vb;
            la = m[2] ? va : (m[0] ? rb : lb);
        end
        chk(36'(oe_a), 36'({16{!m[2]}}));
        chk(36'(oe_b), 36'({16{m[3]}}));
        chk(36'(w_a), 36'(la));
        chk(36'(w_b), 36'(lb));
        if (cp != 0) begin
            ck_a <= {2{cp[0]}};
            ck_b <= {2{cp[1]}};
            @(posedge i_clk);
            ra = cp[0] ? la : ra;
            rb = cp[1] ? lb : rb;
            exp_q.push_back({{2{cp[1]}}, {2{cp[0]}}, rb, ra});
            @(posedge i_clk);
            ck_a <= '0;
            ck_b <= '0;
            repeat (2) @(posedge i_clk);
        end
    endtask
    always @(posedge i_clk) begin
        if (sv && rdy) begin
            chk(sd, exp_q.pop_front());
        end
        rdy <= !stall && 1'($urandom);
    end
    initial begin
        forever #2 i_clk = ~i_clk;
    end
    initial begin
        #40000;
        failures++;
        final_report();
    end
    initial begin
        void'($urandom(32'hF7C19108));
        repeat (12) @(posedge i_clk);
        i_reset <= 1'h0;
        @(posedge i_clk);
        foreach (tbl[i]) begin
            step(tbl[i][5:2], tbl[i][1:0]);
        end
        repeat (30) begin
            c = 4'($urandom);
            c = (c == 4'h8 && la !== lb) ? 4'h0 : c;
            step(c, (c[1] | c[0]) ? 2'($urandom_range(1, 2)) : 2'($urandom));
        end
        for (int i = 0; i < 300 && exp_q.size() > 0; i++) begin
            @(posedge i_clk);
        end
        chk(36'(exp_q.size()), 36'h0);
        stall <= 1'h1;
        repeat (20) step(4'h4, 2'h1);
        #1;
        chk(36'({so, sp}), 36'h2);
        i_reset <= 1'h1;
        repeat (2) @(posedge i_clk);
        #1;
        chk(36'({so, sv, oe_a}), 36'h0);
        final_report();
    end
endmodule
